// file: bench/tsc_host_model.sv
// Host and line model: path pin, keying pin and detector echo
`timescale 1ns/1ps
`default_nettype none
module tsc_host_model #(
   parameter int HALF = 8
) (
   input wire logic aclk,
   input wire logic [1:0] path_req,
   input wire logic [1:0] key_req,
   input wire logic [1:0] echo_en,
   output logic [1:0] tx_path_enable = 2'h0,
   output logic [1:0] tone_key_in = 2'h0,
   output logic [1:0] tone_detector_in = 2'h0
);
   int div = 0;
   // Keying is gated by the path so the key is never high without the path
   always @(posedge aclk) begin
      tx_path_enable <= path_req;
      tone_key_in <= key_req & path_req;
      div <= (div == HALF - 1) ? 0 : div + 1;
      if (div == HALF - 1) begin
         tone_detector_in <= tone_detector_in ^ echo_en; // Quiet line holds its level
      end
   end
endmodule
`default_nettype wire

// file: bench/tsc_top_sva.sv
// Assertion checker for the tone signalling control block
`timescale 1ns/1ps
`default_nettype none
module tsc_top_sva #(
   parameter int TONE_PERIOD = 16
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [1:0] tx_path_enable,
   input wire logic [1:0] tone_key_in,
   input wire logic [1:0] tone_detector_in,
   input wire logic [1:0] tone_tx_out,
   input wire logic [1:0] tone_tx_oe,
   input wire logic [1:0] dc_supply_out,
   input wire logic [1:0] rx_keyed_data_out
);
   localparam int HALF = TONE_PERIOD / 2;
   int kcnt_ff, scnt_ff, dcnt_ff;
   logic out_q_ff, det_q_ff;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Run lengths on section A; tone count restarts whenever the line is idle
   always_ff @(posedge aclk) begin
      out_q_ff <= tone_tx_out[0];
      det_q_ff <= tone_detector_in[0];
      kcnt_ff <= (!aresetn || !tone_key_in[0]) ? 0 : kcnt_ff + 1;
      scnt_ff <= (!tone_tx_oe[0] || tone_tx_out[0] != out_q_ff) ? 0 : scnt_ff + 1;
      dcnt_ff <= (!aresetn || tone_detector_in[0] != det_q_ff) ? 0 : dcnt_ff + 1;
   end
   // Keying held long enough with path and supply up
   sequence s_key_run;
      (tx_path_enable[0] && dc_supply_out[0]) [*4] ##0 kcnt_ff == HALF + 6;
   endsequence
   idle_low_a: assert property (!tone_tx_oe[0] |-> !tone_tx_out[0])
      else $error("tone A while idle");
   idle_b_a: assert property (!tone_tx_oe[1] |-> !tone_tx_out[1])
      else $error("tone B while idle");
   standby_oe_a: assert property (!dc_supply_out[0] && !$past(dc_supply_out[0])
      |-> !tone_tx_oe[0]) else $error("tone in standby");
   standby_rx_a: assert property (!dc_supply_out[0] && !$past(dc_supply_out[0])
      |-> !rx_keyed_data_out[0]) else $error("rx in standby");
   tone_half_a: assert property (tone_tx_oe[0] && $past(tone_tx_oe[0])
      && $changed(tone_tx_out[0]) |-> scnt_ff >= HALF - 2 && scnt_ff <= HALF)
      else $error("tone half period wrong");
   tone_stall_a: assert property (tone_tx_oe[0] |-> scnt_ff <= HALF + 1)
      else $error("tone stalled");
   key_start_a: assert property (s_key_run |-> tone_tx_oe[0])
      else $error("keyed tone late");
   rx_quiet_a: assert property (dcnt_ff > 2 * TONE_PERIOD + 6 |-> !rx_keyed_data_out[0])
      else $error("rx without detector edges");
endmodule
bind tsc_top tsc_top_sva #(.TONE_PERIOD(TONE_PERIOD)) i_tsc_top_sva (.aclk(aclk),
   .aresetn(aresetn), .tx_path_enable(tx_path_enable), .tone_key_in(tone_key_in),
   .tone_detector_in(tone_detector_in), .tone_tx_out(tone_tx_out), .tone_tx_oe(tone_tx_oe),
   .dc_supply_out(dc_supply_out), .rx_keyed_data_out(rx_keyed_data_out));
`default_nettype wire

// file: bench/tsc_top_test.sv
// Self-checking bench for the tone signalling control block
`timescale 1ns/1ps
`default_nettype none
module tsc_top_test;
   localparam int PER = 16;
   localparam int HALF = PER / 2;
   logic aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
   logic bready = 1'h0, arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [1:0] path_req = 2'h0, key_req = 2'h0, echo_en = 2'h0, bresp, rresp, resp;
   logic [1:0] path, key, det, tx, oe, dc, rx;
   logic [5:0] obs;
   logic ce = 1'h1;
   logic [3:0] strb = 4'hf;
   int n_fail = 0, checks_done = 0, cyc = 0, n;
   assign obs = {dc, rx, oe};
   always #5 aclk = ~aclk;
   tsc_top #(.TONE_PERIOD(PER)) i_tsc_top (.aclk(aclk), .aresetn(aresetn), .ce(ce),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(strb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .tx_path_enable(path), .tone_key_in(key),
      .tone_detector_in(det), .tone_tx_out(tx), .tone_tx_oe(oe), .dc_supply_out(dc),
      .rx_keyed_data_out(rx));
   tsc_host_model #(.HALF(HALF)) i_tsc_host_model (.aclk(aclk), .path_req(path_req),
      .key_req(key_req), .echo_en(echo_en), .tx_path_enable(path), .tone_key_in(key),
      .tone_detector_in(det));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      resp = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rd = rdata;
      resp = rresp;
      rready <= 1'h0;
   endtask
   // Cycles until an observed output reaches a level, capped
   task automatic wt(input int k, input logic v);
      n = 0;
      while (n < 300 && obs[k] !== v) begin
         @(posedge aclk);
         n++;
      end
   endtask
   task automatic results;
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Run is a few hundred cycles; the ceiling only catches a hang
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         results;
      end
   end
   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      rd_reg(8'h00);
      chk("ctrl a", 32'h0, rd);
      rd_reg(8'h0c);
      chk("unmapped", 32'h2, 32'(resp));
      wr(8'h08, 32'h7);
      chk("status wr", 32'h2, 32'(resp));
      wr(8'h00, 32'h1);
      chk("supply a", 32'h1, 32'(dc));
      path_req <= 2'h1;
      repeat (6) @(posedge aclk);
      key_req <= 2'h1;
      wt(0, 1'h1);
      chk("start", 32'h1, 32'(n > HALF && n <= HALF + 6));
      repeat (3 * PER) @(posedge aclk);
      chk("oe b", 32'h0, 32'(oe[1]));
      key_req <= 2'h0;
      wt(0, 1'h0);
      chk("stop", 32'h1, 32'(n > PER && n <= PER + 6));
      path_req <= 2'h0;
      wr(8'h00, 32'h7);
      wt(0, 1'h1);
      chk("cont", 32'h1, 32'(n < 8));
      rd_reg(8'h08);
      chk("status", 32'h3, rd);
      wr(8'h00, 32'h3);
      wt(0, 1'h0);
      chk("no path", 32'h1, 32'(n < 8));
      path_req <= 2'h1;
      wt(0, 1'h1);
      chk("pin path", 32'h1, 32'(n < 8));
      echo_en <= 2'h3;
      wt(2, 1'h1);
      chk("rx a", 32'h1, 32'(n < 4 * PER));
      chk("rx b", 32'h0, 32'(rx[1]));
      echo_en <= 2'h0;
      wt(2, 1'h0);
      chk("rx end", 32'h1, 32'(n > PER && n <= 2 * PER + 6));
      path_req <= 2'h0;
      wr(8'h00, 32'h0);
      // Tone gate is registered from the supply bit, so it falls one cycle later
      @(posedge aclk);
      chk("standby", 32'h0, 32'({dc[0], oe[0]}));
      wr(8'h04, 32'h7);
      wt(1, 1'h1);
      chk("oe b on", 32'h1, 32'(n < 8));
      chk("oe a off", 32'h0, 32'(oe[0]));
      // Burst on B has just begun low; a frozen block must not toggle it
      ce <= 1'h0;
      repeat (HALF + 1) @(posedge aclk);
      chk("freeze", 32'h22, 32'({tx, obs}));
      ce <= 1'h1;
      // Lane zero strobe low leaves the control bits alone
      strb <= 4'he;
      wr(8'h04, 32'h0);
      chk("strobe", 32'h1, 32'(dc[1]));
      chk("strobe resp", 32'h0, 32'(resp));
      strb <= 4'hf;
      repeat (2 * PER) @(posedge aclk);
      results;
   end
endmodule
`default_nettype wire

// file: verilog/tsc_defs.svh
// Constants for the tone signalling control block
`ifndef TSC_DEFS_SVH
`define TSC_DEFS_SVH
`define TSC_CLK_HZ 100000000
`define TSC_TONE_HZ 22000
`define TSC_TONE_PERIOD_CYC (`TSC_CLK_HZ / `TSC_TONE_HZ)
`define TSC_START_DLY_HALF_CYC 1
`define TSC_STOP_DLY_CYC 1
`define TSC_DET_HOLD_CYC 2
`define TSC_OFS_CTRL_A 8'h00
`define TSC_OFS_CTRL_B 8'h04
`define TSC_OFS_STATUS 8'h08
`define TSC_BIT_SUPPLY_EN 0
`define TSC_BIT_CONT_TONE 1
`define TSC_BIT_TX_PATH 2
`define TSC_STAT_SEC_B_LSB 8
`define TSC_RESP_OKAY 2'h0
`define TSC_RESP_SLVERR 2'h2
`endif

// file: verilog/tsc_pkg.sv
// Types for the tone signalling control block
package tsc_pkg;
   typedef enum logic [1:0] {
      TSC_KEY_IDLE,
      TSC_KEY_START,
      TSC_KEY_ON,
      TSC_KEY_STOP
   } tsc_key_type;
   typedef struct packed {
      logic supply_en;
      logic continuous_tone_bit;
      logic tx_path_bit;
      logic key_s1;
      logic key_s2;
      logic ttx_s1;
      logic ttx_s2;
      logic det_s1;
      logic det_s2;
      logic det_prev;
      tsc_key_type kst;
      logic [12:0] dcnt;
      logic [12:0] tcnt;
      logic phase;
      logic active;
      logic [13:0] det_cnt;
      logic rx;
   } tsc_sec_type;
   typedef struct packed {
      tsc_sec_type [1:0] sec;
      logic aw_full;
      logic [7:0] awaddr;
      logic w_full;
      logic [31:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tsc_state_type;
endpackage

// file: verilog/tsc_top.sv
// Tone signalling control: two sections behind an AXI4-Lite slave
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tsc_defs.svh"
module tsc_top #(
   parameter int TONE_PERIOD = `TSC_TONE_PERIOD_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [1:0] tx_path_enable,
   input wire logic [1:0] tone_key_in,
   input wire logic [1:0] tone_detector_in,
   output logic [1:0] tone_tx_out,
   output logic [1:0] tone_tx_oe,
   output logic [1:0] dc_supply_out,
   output logic [1:0] rx_keyed_data_out
);
   // Delays measured in clock cycles, derived from the timebase
   localparam int START_CYC = (TONE_PERIOD * `TSC_START_DLY_HALF_CYC) / 2;
   localparam int STOP_CYC = TONE_PERIOD * `TSC_STOP_DLY_CYC;
   localparam int DET_CYC = TONE_PERIOD * `TSC_DET_HOLD_CYC;

   tsc_pkg::tsc_state_type st_ff;
   tsc_pkg::tsc_state_type nxt_st;

   // Effective transmit path: pin OR bus bit
   function automatic logic ttx_eff(input tsc_pkg::tsc_sec_type s);
      ttx_eff = s.ttx_s2 | s.tx_path_bit;
   endfunction

   // Keying counts as active from start delay end to stop delay end
   function automatic logic key_act(input tsc_pkg::tsc_sec_type s);
      key_act = (s.kst == tsc_pkg::TSC_KEY_ON) || (s.kst == tsc_pkg::TSC_KEY_STOP);
   endfunction

   // Per-section status nibble
   function automatic logic [3:0] sec_stat(input tsc_pkg::tsc_sec_type s);
      sec_stat = {s.rx, key_act(s), s.active, ttx_eff(s)};
   endfunction

   // Register read decode, unmapped addresses flagged
   function automatic logic [32:0] rd_dec(input tsc_pkg::tsc_state_type s,
                                          input logic [7:0] a);
      logic [31:0] d;
      logic err;
      d = 32'h0;
      err = 1'b0;
      case (a)
         `TSC_OFS_CTRL_A: begin
            d[`TSC_BIT_SUPPLY_EN] = s.sec[0].supply_en;
            d[`TSC_BIT_CONT_TONE] = s.sec[0].continuous_tone_bit;
            d[`TSC_BIT_TX_PATH] = s.sec[0].tx_path_bit;
         end
         `TSC_OFS_CTRL_B: begin
            d[`TSC_BIT_SUPPLY_EN] = s.sec[1].supply_en;
            d[`TSC_BIT_CONT_TONE] = s.sec[1].continuous_tone_bit;
            d[`TSC_BIT_TX_PATH] = s.sec[1].tx_path_bit;
         end
         `TSC_OFS_STATUS: begin
            d[3:0] = sec_stat(s.sec[0]);
            d[`TSC_STAT_SEC_B_LSB +: 4] = sec_stat(s.sec[1]);
         end
         default: begin
            err = 1'b1;
         end
      endcase
      rd_dec = {err, d};
   endfunction

   // Next state: sections then bus
   always_comb begin
      logic [32:0] rd;
      logic go;
      rd = 33'h0;
      go = 1'b0;
      nxt_st = st_ff;
      // Each section runs its own keying, tone and detector logic
      for (int i = 0; i < 2; i++) begin
         // Two-stage synchronisers on every pin input
         nxt_st.sec[i].key_s1 = tone_key_in[i];
         nxt_st.sec[i].key_s2 = st_ff.sec[i].key_s1;
         nxt_st.sec[i].ttx_s1 = tx_path_enable[i];
         nxt_st.sec[i].ttx_s2 = st_ff.sec[i].ttx_s1;
         nxt_st.sec[i].det_s1 = tone_detector_in[i];
         nxt_st.sec[i].det_s2 = st_ff.sec[i].det_s1;
         nxt_st.sec[i].det_prev = st_ff.sec[i].det_s2;
         nxt_st.sec[i].dcnt = st_ff.sec[i].dcnt + 13'h1;
         // Keying delay machine: half cycle on, full cycle off
         case (st_ff.sec[i].kst)
            tsc_pkg::TSC_KEY_IDLE: begin
               if (st_ff.sec[i].key_s2) begin
                  nxt_st.sec[i].kst = tsc_pkg::TSC_KEY_START;
                  nxt_st.sec[i].dcnt = 13'h0;
               end
            end
            tsc_pkg::TSC_KEY_START: begin
               // A glitch shorter than the delay never reaches the line
               if (!st_ff.sec[i].key_s2) begin
                  nxt_st.sec[i].kst = tsc_pkg::TSC_KEY_IDLE;
               end else if (st_ff.sec[i].dcnt == 13'(START_CYC - 1)) begin
                  nxt_st.sec[i].kst = tsc_pkg::TSC_KEY_ON;
               end
            end
            tsc_pkg::TSC_KEY_ON: begin
               if (!st_ff.sec[i].key_s2) begin
                  nxt_st.sec[i].kst = tsc_pkg::TSC_KEY_STOP;
                  nxt_st.sec[i].dcnt = 13'h0;
               end
            end
            tsc_pkg::TSC_KEY_STOP: begin
               if (st_ff.sec[i].key_s2) begin
                  nxt_st.sec[i].kst = tsc_pkg::TSC_KEY_ON;
               end else if (st_ff.sec[i].dcnt == 13'(STOP_CYC - 1)) begin
                  nxt_st.sec[i].kst = tsc_pkg::TSC_KEY_IDLE;
               end
            end
            default: begin
               nxt_st.sec[i].kst = tsc_pkg::TSC_KEY_IDLE;
            end
         endcase
         // Tone gate: supply on, path enabled, and tone bit or key
         nxt_st.sec[i].active = st_ff.sec[i].supply_en & ttx_eff(st_ff.sec[i])
                                & (st_ff.sec[i].continuous_tone_bit
                                   | key_act(st_ff.sec[i]));
         // Tone generator restarts in phase at each burst
         if (!st_ff.sec[i].active) begin
            nxt_st.sec[i].tcnt = 13'h0;
            nxt_st.sec[i].phase = 1'b0;
         end else if (st_ff.sec[i].tcnt == 13'(TONE_PERIOD / 2 - 1)) begin
            nxt_st.sec[i].tcnt = 13'h0;
            nxt_st.sec[i].phase = ~st_ff.sec[i].phase;
         end else begin
            nxt_st.sec[i].tcnt = st_ff.sec[i].tcnt + 13'h1;
         end
         // Envelope detector: any edge holds data high for two tone periods
         if (st_ff.sec[i].det_s2 != st_ff.sec[i].det_prev) begin
            nxt_st.sec[i].det_cnt = 14'(DET_CYC);
         end else if (st_ff.sec[i].det_cnt != 14'h0) begin
            nxt_st.sec[i].det_cnt = st_ff.sec[i].det_cnt - 14'h1;
         end
         nxt_st.sec[i].rx = st_ff.sec[i].supply_en
                            & (st_ff.sec[i].det_cnt != 14'h0);
      end
      // Write address and data captured in either order
      if (awvalid && awready) begin
         nxt_st.aw_full = 1'b1;
         nxt_st.awaddr = awaddr;
      end
      if (wvalid && wready) begin
         nxt_st.w_full = 1'b1;
         nxt_st.wdata = wdata;
         nxt_st.wstrb0 = wstrb[0];
      end
      // Commit once both halves are held
      if (st_ff.aw_full && st_ff.w_full && !st_ff.bvalid) begin
         go = 1'b1;
         nxt_st.aw_full = 1'b0;
         nxt_st.w_full = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = `TSC_RESP_OKAY;
      end
      // Bus writes to control; status is read-only and refused
      if (go) begin
         if (st_ff.awaddr == `TSC_OFS_CTRL_A || st_ff.awaddr == `TSC_OFS_CTRL_B) begin
            for (int i = 0; i < 2; i++) begin
               if (st_ff.wstrb0 && st_ff.awaddr[2] == i[0]) begin
                  nxt_st.sec[i].supply_en = st_ff.wdata[`TSC_BIT_SUPPLY_EN];
                  nxt_st.sec[i].continuous_tone_bit = st_ff.wdata[`TSC_BIT_CONT_TONE];
                  nxt_st.sec[i].tx_path_bit = st_ff.wdata[`TSC_BIT_TX_PATH];
               end
            end
         end else begin
            nxt_st.bresp = `TSC_RESP_SLVERR;
         end
      end
      if (st_ff.bvalid && bready) begin
         nxt_st.bvalid = 1'b0;
      end
      // Reads answer one cycle after acceptance
      if (arvalid && arready) begin
         rd = rd_dec(st_ff, araddr);
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rd[31:0];
         nxt_st.rresp = rd[32] ? `TSC_RESP_SLVERR : `TSC_RESP_OKAY;
      end else if (st_ff.rvalid && rready) begin
         nxt_st.rvalid = 1'b0;
      end
   end

   // Single state register; clock enable freezes everything
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= '0;
      end else if (ce) begin
         st_ff <= nxt_st;
      end
   end

   // Handshake outputs decoded from held state
   assign awready = !st_ff.aw_full && !st_ff.bvalid;
   assign wready = !st_ff.w_full && !st_ff.bvalid;
   assign arready = !st_ff.rvalid;
   assign bvalid = st_ff.bvalid;
   assign bresp = st_ff.bresp;
   assign rvalid = st_ff.rvalid;
   assign rdata = st_ff.rdata;
   assign rresp = st_ff.rresp;

   // Line-side outputs, all from flip-flops
   for (genvar g = 0; g < 2; g++) begin : g_sec
      assign tone_tx_out[g] = st_ff.sec[g].phase & st_ff.sec[g].active;
      assign tone_tx_oe[g] = st_ff.sec[g].active;
      // Supply line stays up whenever the section is enabled
      assign dc_supply_out[g] = st_ff.sec[g].supply_en;
      assign rx_keyed_data_out[g] = st_ff.sec[g].rx;
   end
endmodule
`default_nettype wire
